/* hw/accr_defs.svh */
// Purpose: constants for the acquisition chain control registers
// Assumes: byte offsets within the global address space
// Notes:
`ifndef ACCR_DEFS_SVH
`define ACCR_DEFS_SVH
`define ACCR_BASE_BLOCKING    16'h0E00
`define ACCR_BASE_NONBLOCKING 16'h0F00
`define ACCR_OFS_CHAIN        8'h5C
`define ACCR_OFS_SHORT        8'h5E
`define ACCR_OFS_RATE         8'h60
`define ACCR_MASK_SHIFT       8
`define ACCR_CHAIN_RESET      8'hE1
`define ACCR_SHORT_BIT        7
`define ACCR_RATE_RESET       3'h4
`define ACCR_FIRST_STAGE      11'h008
`endif

/* hw/accr_pkg.sv */
// Purpose: types for the acquisition chain control registers
// Assumes: nothing
// Notes: ratio type covers up to 1024
package accr_pkg;
    typedef logic [10:0] accr_ratio_t;
    typedef logic [2:0]  accr_rate_t;
endpackage

/* hw/accr_regs.sv */
// Purpose: control registers of the acquisition chain, masked except the rate register
// Assumes: single-cycle synchronous bus, 16-bit data, byte address
// Notes: read data is registered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "accr_defs.svh"
module accr_regs
    import accr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        bus_sel,
    input  wire logic        bus_write,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    output logic             bus_hit,
    output logic             temp_comp_enable,
    output logic             volt_comp_enable,
    output logic             curr_comp_enable,
    output logic             lowpass_enable,
    output logic             ext_temp_chopper_enable,
    output logic             int_temp_chopper_enable,
    output logic             volt_chopper_enable,
    output logic             auto_gain_enable,
    output logic             input_short_enable,
    output logic       [2:0] rate_code,
    output logic      [10:0] decim_ratio,
    output logic      [10:0] second_stage_ratio
);
    function automatic accr_ratio_t ratio_of(input accr_rate_t c);
        unique case (c)
            3'h1:    ratio_of = 11'h040;
            3'h2:    ratio_of = 11'h080;
            3'h3:    ratio_of = 11'h100;
            3'h5:    ratio_of = 11'h400;
            default: ratio_of = 11'h200;
        endcase
    endfunction

    logic [7:0]  chain_q;
    logic [7:0]  chain_d;
    logic        short_q;
    logic        short_d;
    accr_rate_t  rate_q;
    accr_rate_t  rate_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    default clocking dflt_cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // either alias reaches the same registers
    wire [7:0]   base_blk = 8'(`ACCR_BASE_BLOCKING >> 8);
    wire [7:0]   base_nbl = 8'(`ACCR_BASE_NONBLOCKING >> 8);
    wire         in_blk  = bus_addr[15:8] == base_blk;
    wire         in_nbl  = bus_addr[15:8] == base_nbl;
    wire         in_win  = bus_sel && (in_blk || in_nbl);
    wire [7:0]   ofs     = bus_addr[7:0];
    wire         hit_ch  = in_win && ofs == `ACCR_OFS_CHAIN;
    wire         hit_sh  = in_win && ofs == `ACCR_OFS_SHORT;
    wire         hit_rt  = in_win && ofs == `ACCR_OFS_RATE;
    wire [7:0]   wmask   = bus_wdata[15:`ACCR_MASK_SHIFT];
    wire         wr_ch   = bus_write && hit_ch;
    wire         wr_sh   = bus_write && hit_sh;
    wire         wr_rt   = bus_write && hit_rt;

    // byte writes are not supported, so the mask byte is always present
    assign chain_d = wr_ch ? ((chain_q & ~wmask) | (bus_wdata[7:0] & wmask))
                           : chain_q;
    assign short_d = (wr_sh && bus_wdata[15]) ?
                     bus_wdata[`ACCR_SHORT_BIT] : short_q;
    assign rate_d  = wr_rt ? bus_wdata[2:0] : rate_q;
    assign rdata_d = !(bus_sel && !bus_write) ? 16'h0000 :
                     hit_ch ? {8'h00, chain_q} :
                     hit_sh ? {8'h00, short_q, 7'h00} :
                     hit_rt ? {13'h0000, rate_q} : 16'h0000;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            chain_q <= `ACCR_CHAIN_RESET;
            short_q <= 1'b0;
            rate_q  <= `ACCR_RATE_RESET;
            rdata_q <= 16'h0000;
        end else begin
            chain_q <= chain_d;
            short_q <= short_d;
            rate_q  <= rate_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata               = rdata_q;
    assign bus_hit                 = hit_ch || hit_sh || hit_rt;
    assign temp_comp_enable        = chain_q[7];
    assign volt_comp_enable        = chain_q[6];
    assign curr_comp_enable        = chain_q[5];
    assign lowpass_enable          = chain_q[4];
    assign ext_temp_chopper_enable = chain_q[3];
    assign int_temp_chopper_enable = chain_q[2];
    assign volt_chopper_enable     = chain_q[1];
    assign auto_gain_enable        = chain_q[0];
    assign input_short_enable      = short_q;
    assign rate_code               = rate_q;
    assign decim_ratio             = ratio_of(rate_q);
    // second stage carries the ratio above the fixed first stage
    assign second_stage_ratio      = ratio_of(rate_q) >> 3;

    // each enable bit must follow its own mask, never a neighbour's
    unmasked_keep_a: assert property (
        (wr_ch && wmask == 8'h00) |=> $stable(chain_q))
        else $error("chain bits changed without mask");
    masked_set_a: assert property (
        (wr_ch && bus_wdata[15]) |=>
        temp_comp_enable == $past(bus_wdata[7]))
        else $error("temperature compensation not written");
    volt_set_a: assert property (
        (wr_ch && bus_wdata[14]) |=>
        volt_comp_enable == $past(bus_wdata[6]))
        else $error("voltage compensation not written");
    curr_set_a: assert property (
        (wr_ch && bus_wdata[13]) |=>
        curr_comp_enable == $past(bus_wdata[5]))
        else $error("current compensation not written");
    lowpass_set_a: assert property (
        (wr_ch && bus_wdata[12]) |=>
        lowpass_enable == $past(bus_wdata[4]))
        else $error("filter enable not written");
    ext_chop_set_a: assert property (
        (wr_ch && bus_wdata[11]) |=>
        ext_temp_chopper_enable == $past(bus_wdata[3]))
        else $error("external chopper not written");
    int_chop_set_a: assert property (
        (wr_ch && bus_wdata[10]) |=>
        int_temp_chopper_enable == $past(bus_wdata[2]))
        else $error("internal chopper not written");
    volt_chop_set_a: assert property (
        (wr_ch && bus_wdata[9]) |=>
        volt_chopper_enable == $past(bus_wdata[1]))
        else $error("voltage chopper not written");
    auto_gain_set_a: assert property (
        (wr_ch && bus_wdata[8]) |=>
        auto_gain_enable == $past(bus_wdata[0]))
        else $error("auto gain not written");

    // a clear mask bit must shield its enable even when others are set
    temp_keep_a: assert property (
        (wr_ch && !bus_wdata[15]) |=> $stable(temp_comp_enable))
        else $error("temperature compensation changed unmasked");
    volt_keep_a: assert property (
        (wr_ch && !bus_wdata[14]) |=> $stable(volt_comp_enable))
        else $error("voltage compensation changed unmasked");
    curr_keep_a: assert property (
        (wr_ch && !bus_wdata[13]) |=> $stable(curr_comp_enable))
        else $error("current compensation changed unmasked");
    lowpass_keep_a: assert property (
        (wr_ch && !bus_wdata[12]) |=> $stable(lowpass_enable))
        else $error("filter enable changed unmasked");
    ext_chop_keep_a: assert property (
        (wr_ch && !bus_wdata[11]) |=> $stable(ext_temp_chopper_enable))
        else $error("external chopper changed unmasked");
    int_chop_keep_a: assert property (
        (wr_ch && !bus_wdata[10]) |=> $stable(int_temp_chopper_enable))
        else $error("internal chopper changed unmasked");
    volt_chop_keep_a: assert property (
        (wr_ch && !bus_wdata[9]) |=> $stable(volt_chopper_enable))
        else $error("voltage chopper changed unmasked");
    auto_gain_keep_a: assert property (
        (wr_ch && !bus_wdata[8]) |=> $stable(auto_gain_enable))
        else $error("auto gain changed unmasked");

    short_keep_a: assert property (
        (wr_sh && !bus_wdata[15]) |=> $stable(input_short_enable))
        else $error("short bit changed without mask");
    short_set_a: assert property (
        (wr_sh && bus_wdata[15]) |=> input_short_enable == $past(bus_wdata[7]))
        else $error("short bit not written");
    alias_same_a: assert property (
        (wr_rt && in_nbl) |=> rate_code == $past(bus_wdata[2:0]))
        else $error("non-blocking alias write lost");
    rate_write_a: assert property (
        wr_rt |=> rate_code == $past(bus_wdata[2:0]))
        else $error("rate code not written");
    miss_keep_a: assert property (
        (bus_sel && bus_write && !bus_hit) |=>
        $stable(chain_q) && $stable(short_q) && $stable(rate_q))
        else $error("unmapped write changed a register");

    ratio_64_a: assert property (
        rate_code == 3'h1 |-> decim_ratio == 11'h040)
        else $error("ratio for code 1 wrong");
    ratio_128_a: assert property (
        rate_code == 3'h2 |-> decim_ratio == 11'h080)
        else $error("ratio for code 2 wrong");
    ratio_256_a: assert property (
        rate_code == 3'h3 |-> decim_ratio == 11'h100)
        else $error("ratio for code 3 wrong");
    ratio_map_a: assert property (
        rate_code == 3'h5 |-> decim_ratio == 11'h400)
        else $error("ratio for code 5 wrong");
    ratio_dflt_a: assert property (
        rate_code[2] && !rate_code[0] |-> decim_ratio == 11'h200)
        else $error("default ratio wrong");

    mask_read_a: assert property (
        (bus_sel && !bus_write && bus_hit) |=> bus_rdata[15:8] == 8'h00)
        else $error("upper byte not zero");
    short_read_a: assert property (
        (bus_sel && !bus_write && hit_sh) |=>
        bus_rdata == {8'h00, $past(short_q), 7'h00})
        else $error("short register read wrong");
    rate_read_a: assert property (
        (bus_sel && !bus_write && hit_rt) |=>
        bus_rdata == {13'h0000, $past(rate_q)})
        else $error("rate register read wrong");
    idle_read_a: assert property (
        !(bus_sel && !bus_write) |=> bus_rdata == 16'h0000)
        else $error("read data without read request");
    stage_prod_a: assert property (
        second_stage_ratio * `ACCR_FIRST_STAGE == {3'h0, decim_ratio})
        else $error("stage ratios inconsistent");

    mask_wr_c: cover property (
        wr_ch && wmask == 8'hFF);
    short_on_c: cover property (
        $rose(input_short_enable));
    rate_64_c: cover property (
        decim_ratio == 11'h040);
    alias_rd_c: cover property (
        bus_sel && !bus_write && in_nbl && bus_hit);
    rate_1024_c: cover property (
        decim_ratio == 11'h400);
endmodule // accr_regs
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench for the acquisition chain control registers
// Assumes: one access per sel pulse, read data one cycle after the request
// Notes: every access is a full 16-bit word, masks in the high byte
`timescale 1ns/1ps
`default_nettype none
`include "accr_defs.svh"
module tb_top
    import accr_pkg::*;
;
    logic clock = 1'b0, arst_n = 1'b0, sel = 1'b0, wr = 1'b0, hit_seen;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000;
    wire logic [15:0] rdata;
    wire logic hit, tc, vc, cc, lp, et, it, vh, ag, shrt;
    wire logic [2:0]  rc;
    wire logic [10:0] dr, sr;
    wire logic [7:0]  chain_w = {tc, vc, cc, lp, et, it, vh, ag};
    logic [7:0]  exp_q;
    int err_total = 0, n_compared = 0, cyc = 0;
    accr_regs u_dut (.clock(clock), .arst_n(arst_n), .bus_sel(sel),
        .bus_write(wr), .bus_addr(addr), .bus_wdata(wdata),
        .bus_rdata(rdata), .bus_hit(hit), .temp_comp_enable(tc),
        .volt_comp_enable(vc), .curr_comp_enable(cc), .lowpass_enable(lp),
        .ext_temp_chopper_enable(et), .int_temp_chopper_enable(it),
        .volt_chopper_enable(vh), .auto_gain_enable(ag),
        .input_short_enable(shrt), .rate_code(rc), .decim_ratio(dr),
        .second_stage_ratio(sr));
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // full word access; request held until the edge that takes it
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge clock);
        sel <= 1'b1; wr <= w; addr <= a; wdata <= d;
        @(posedge clock);
        hit_seen = hit;
        sel <= 1'b0; wr <= 1'b0;
        #1;
    endtask
    function automatic logic [10:0] ratio(input logic [2:0] c);
        case (c)
            3'h1: ratio = 11'h040;
            3'h2: ratio = 11'h080;
            3'h3: ratio = 11'h100;
            3'h5: ratio = 11'h400;
            default: ratio = 11'h200;
        endcase
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        #1 chk({8'h00, chain_w}, 16'h00E1);
        chk({12'h000, shrt, rc}, 16'h0004);
        chk({5'h00, dr}, 16'h0200);
        acc(1'b0, 16'h0F5C, 16'h0000);
        chk(rdata, 16'h00E1);
        acc(1'b1, 16'h0E5C, 16'h001E);
        chk({8'h00, chain_w}, 16'h00E1);
        exp_q = 8'hE1;
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, i[0] ? 16'h0F5C : 16'h0E5C, {8'h01 << i, ~exp_q});
            exp_q[i] = ~exp_q[i];
            chk({8'h00, chain_w}, {8'h00, exp_q});
            chk({15'h0, chain_w[i]}, {15'h0, exp_q[i]});
        end
        acc(1'b0, 16'h0E5C, 16'h0000);
        chk(rdata, {8'h00, exp_q});
        $display("chain mask test done");
        acc(1'b1, 16'h0E5E, 16'h7FFF);
        chk({15'h0000, shrt}, 16'h0000);
        acc(1'b1, 16'h0F5E, 16'h80FF);
        chk({15'h0000, shrt}, 16'h0001);
        acc(1'b0, 16'h0E5E, 16'h0000);
        chk(rdata, 16'h0080);
        $display("input short test done");
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, c[0] ? 16'h0E60 : 16'h0F60, {13'h1FFF, c[2:0]});
            chk({5'h00, dr}, {5'h00, ratio(c[2:0])});
            chk({5'h00, sr}, {5'h00, ratio(c[2:0]) >> 3});
            chk({13'h0000, rc}, {13'h0000, c[2:0]});
            acc(1'b0, 16'h0E60, 16'h0000);
            chk(rdata, {13'h0000, c[2:0]});
        end
        $display("rate test done");
        acc(1'b1, 16'h0D5C, 16'hFF00);
        chk({15'h0000, hit_seen}, 16'h0000);
        chk({8'h00, chain_w}, {8'h00, exp_q});
        acc(1'b0, 16'h0E5A, 16'h0000);
        chk(rdata, 16'h0000);
        $display("unmapped test done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
